// *** verilog/twsl_pkg.sv ***
// package for the two-wire slave / software master port
// assumes an 8-bit special function register port on the core clock
package twsl_pkg;
   // register addresses
   localparam logic [7:0] ADDR_BUS_DATA = 8'h9a;
   localparam logic [7:0] ADDR_OWN_SLAVE_ADDRESS = 8'h9b;
   localparam logic [7:0] ADDR_TWO_WIRE_CONTROL = 8'he8;
   // reset values
   localparam logic [7:0] RST_BUS_DATA = 8'h00;
   localparam logic [7:0] RST_OWN_SLAVE_ADDRESS = 8'h55;
   localparam logic [7:0] RST_TWO_WIRE_CONTROL = 8'h00;
   // control field positions
   localparam int BIT_SW_MASTER_DATA_OUT = 7;
   localparam int BIT_SW_MASTER_DRIVE_ENABLE = 6;
   localparam int BIT_SW_MASTER_CLOCK_OUT = 5;
   localparam int BIT_SW_MASTER_DATA_IN = 4;
   localparam int BIT_MASTER_SELECT = 3;
   localparam int BIT_INTERFACE_RESET = 2;
   localparam int BIT_TRANSFER_DIRECTION = 1;
   localparam int BIT_BYTE_DONE = 0;
   // bits in a byte, counter width
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } twsl_sfr_req_t;

   // slave sequencer states, one-hot
   typedef enum logic [4:0] {
      ST_IDLE = 5'b0_0001,
      ST_ADDR = 5'b0_0010,
      ST_RX = 5'b0_0100,
      ST_TX = 5'b0_1000,
      ST_ACK = 5'b1_0000
   } twsl_state_t;
endpackage : twsl_pkg

// *** verilog/twsl_port.sv ***
// two-wire port: hardware slave plus software-driven master pins
// assumes pins are open drain, resolved outside; sfr requests on ref_clk
//
// Functional notes
// - slave transfers run in hardware, master is only software pin control.
// - pins are shared with the spi, so this port lets go of them while spi is enabled.
// - in master mode the data-out bit drives the data pin when drive enable is set.
// - in master mode drive enable makes the data pin an output when set, an input when clear.
// - in master mode the clock-out bit appears directly on the clock pin.
// - in master mode with drive enable clear, the data pin is latched into data-in on the clock rise.
// - the master select bit picks software master when set, hardware slave when clear.
// - while the interface reset bit is set the slave logic is held in reset.
// - the direction flag is set while the slave transmits, clear while it receives.
// - the byte-done flag is set after each data byte and raises an interrupt request.
// - an access to the data register clears the byte-done flag and interrupt unless a byte ends in the same cycle.
// - a data write supplies the next transmit byte, a read gives the last received one.
// - the own-address register holds the 7-bit address, resets to 55h, is writable.
`timescale 1ns/1ps
module twsl_port (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // special function register port
   input wire twsl_pkg::twsl_sfr_req_t sfr_req,
   output logic [7:0] sfr_rdata,
   // spi enable from the spi block
   input wire logic spi_enable_bit,
   // serial clock pin
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe,
   // serial data pin
   input wire logic serial_data_pin_i,
   output logic serial_data_pin_o,
   output logic serial_data_pin_oe,
   // interrupt request
   output logic irq
);

   ////////////////////////////////////////////////////////////////////////////
   // pin synchronisers: first stage is read only by the second
   // the pins are asynchronous to ref_clk, so every reaction to the bus
   // lags the pin by about three core cycles; at 200 MHz this is far
   // inside a bit time, but it limits how fast an outside clock may toggle
   // both pins reset high, their released level, so no false edge follows reset
   logic scl_s1_r, scl_s2_r, sda_s1_r, sda_s2_r;
   logic scl_d_r, sda_d_r;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         scl_s1_r <= 1'b1;
         scl_s2_r <= 1'b1;
         sda_s1_r <= 1'b1;
         sda_s2_r <= 1'b1;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else if (clk_en) begin
         scl_s1_r <= serial_clock_pin_i;
         scl_s2_r <= scl_s1_r;
         sda_s1_r <= serial_data_pin_i;
         sda_s2_r <= sda_s1_r;
         scl_d_r <= scl_s2_r;
         sda_d_r <= sda_s2_r;
      end
   end

   // bus events from the synchronised levels
   wire scl_rise = scl_s2_r & ~scl_d_r;
   wire scl_fall = ~scl_s2_r & scl_d_r;
   wire start_det = scl_s2_r & scl_d_r & sda_d_r & ~sda_s2_r;
   wire stop_det = scl_s2_r & scl_d_r & ~sda_d_r & sda_s2_r;

   // start and stop compare the data pin across one delayed sample while
   // the clock has stood high for two samples; data moving on the clock
   // fall never counts as either, because the clock sample drops with it

   ////////////////////////////////////////////////////////////////////////////
   // register decode
   // three registers on the special function register port; the control
   // register mixes software-owned bits with flags owned by the sequencer
   logic [7:0] ctrl_r, own_addr_r, tx_data_r, rx_data_r;
   logic byte_done_r, direction_r, sw_data_in_r;

   // address compare shared by every strobe decode
   function automatic logic addr_hit(input logic [7:0] addr, input logic [7:0] target);
      return addr == target;
   endfunction : addr_hit

   // write and read strobes per register; only the data register cares
   // about reads, because a read of it clears the byte-done flag
   wire wr_ctrl = sfr_req.wr & addr_hit(sfr_req.addr, twsl_pkg::ADDR_TWO_WIRE_CONTROL);
   wire wr_addr = sfr_req.wr & addr_hit(sfr_req.addr, twsl_pkg::ADDR_OWN_SLAVE_ADDRESS);
   wire wr_data = sfr_req.wr & addr_hit(sfr_req.addr, twsl_pkg::ADDR_BUS_DATA);
   wire rd_data = sfr_req.rd & addr_hit(sfr_req.addr, twsl_pkg::ADDR_BUS_DATA);
   wire data_access = wr_data | rd_data;

   wire master_mode = ctrl_r[twsl_pkg::BIT_MASTER_SELECT];
   wire if_reset = ctrl_r[twsl_pkg::BIT_INTERFACE_RESET];
   wire drive_en = ctrl_r[twsl_pkg::BIT_SW_MASTER_DRIVE_ENABLE];
   // slave logic runs only in slave mode, out of reset, with spi off
   wire slave_hold = master_mode | if_reset | spi_enable_bit;
   // a master-mode or spi period also parks the slave, so it never wakes
   // mid-frame on traffic that it did not see from the start

   // control register view with hardware-owned bits merged
   wire [7:0] ctrl_view = {ctrl_r[7:5], sw_data_in_r, ctrl_r[3:2], direction_r, byte_done_r};

   // bits 4, 1 and 0 belong to the hardware; software sees them here but
   // its writes to bits 4 and 1 land in ctrl_r only and are never shown
   // read mux: unmapped addresses read zero
   always_comb begin
      case (sfr_req.addr)
         twsl_pkg::ADDR_TWO_WIRE_CONTROL: sfr_rdata = ctrl_view;
         twsl_pkg::ADDR_OWN_SLAVE_ADDRESS: sfr_rdata = own_addr_r;
         twsl_pkg::ADDR_BUS_DATA: sfr_rdata = rx_data_r;
         default: sfr_rdata = 8'h00;
      endcase
   end

   // software-owned registers
   // writes take effect on the edge that takes the strobe
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         ctrl_r <= twsl_pkg::RST_TWO_WIRE_CONTROL;
         own_addr_r <= twsl_pkg::RST_OWN_SLAVE_ADDRESS;
         tx_data_r <= twsl_pkg::RST_BUS_DATA;
      end else if (clk_en) begin
         if (wr_ctrl) begin
            ctrl_r <= sfr_req.wdata;
         end
         if (wr_addr) begin
            own_addr_r <= sfr_req.wdata;
         end
         if (wr_data) begin
            tx_data_r <= sfr_req.wdata;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // software master data-in: sampled on the clock rise when not driving
   // the latch keeps its value across mode changes, so software should
   // read it only after the clock rise it asked for
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         sw_data_in_r <= 1'b0;
      end else if (clk_en && master_mode && !drive_en && scl_rise) begin
         sw_data_in_r <= sda_s2_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // hardware slave sequencer, software master has pin bits only
   // idle waits for a start; addr shifts the address and read/write bit;
   // rx and tx move one data byte; ack covers the ninth clock in both
   // directions and returns to the state kept in ret_r
   // states are one-hot, a stray code falls back to idle
   twsl_pkg::twsl_state_t state_r, ret_r;
   logic [7:0] shift_r;
   logic [3:0] bit_cnt_r;
   logic ack_drive_r, sda_slave_r, ack_phase_r;

   // address byte matches own 7-bit address
   wire addr_match = (shift_r[7:1] == own_addr_r[6:0]);

   // bit counter has seen a whole byte
   wire byte_full = (bit_cnt_r == twsl_pkg::BITS_PER_BYTE);

   // slave hold, stop and start outrank the state decode, so a cut frame
   // or a repeated start always lands the sequencer in a known state
   // without help from software
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= twsl_pkg::ST_IDLE;
         ret_r <= twsl_pkg::ST_IDLE;
         shift_r <= 8'h00;
         bit_cnt_r <= 4'h0;
         sda_slave_r <= 1'b0;
         ack_drive_r <= 1'b0;
         ack_phase_r <= 1'b0;
         direction_r <= 1'b0;
         byte_done_r <= 1'b0;
         rx_data_r <= twsl_pkg::RST_BUS_DATA;
      end else if (clk_en) begin
         // byte-done: an event in the same cycle as an access wins
         // a control write sets or clears the flag directly, and a set
         // from the sequencer below still wins over that write
         if (data_access) byte_done_r <= 1'b0;
         if (wr_ctrl) byte_done_r <= sfr_req.wdata[twsl_pkg::BIT_BYTE_DONE];
         if (slave_hold) begin
            state_r <= twsl_pkg::ST_IDLE;
            sda_slave_r <= 1'b0;
            ack_drive_r <= 1'b0;
            direction_r <= 1'b0;
         end else if (stop_det) begin
            state_r <= twsl_pkg::ST_IDLE;
            sda_slave_r <= 1'b0;
            ack_drive_r <= 1'b0;
         end else if (start_det) begin
            state_r <= twsl_pkg::ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_slave_r <= 1'b0;
            ack_drive_r <= 1'b0;
         end else begin
            case (state_r)
               twsl_pkg::ST_IDLE: begin
                  ack_drive_r <= 1'b0;
               end
               twsl_pkg::ST_ADDR, twsl_pkg::ST_RX: begin
                  if (scl_rise) begin
                     shift_r <= {shift_r[6:0], sda_s2_r};
                     bit_cnt_r <= bit_cnt_r + 4'h1;
                  end else if (scl_fall && byte_full) begin
                     bit_cnt_r <= 4'h0;
                     if (state_r == twsl_pkg::ST_ADDR) begin
                        if (addr_match) begin
                           ack_drive_r <= 1'b1;
                           direction_r <= shift_r[0];
                           ret_r <= shift_r[0] ? twsl_pkg::ST_TX : twsl_pkg::ST_RX;
                           state_r <= twsl_pkg::ST_ACK;
                        end else begin
                           state_r <= twsl_pkg::ST_IDLE;
                        end
                     end else begin
                        rx_data_r <= shift_r;
                        byte_done_r <= 1'b1;
                        ack_drive_r <= 1'b1;
                        ret_r <= twsl_pkg::ST_RX;
                        state_r <= twsl_pkg::ST_ACK;
                     end
                     ack_phase_r <= 1'b0;
                  end
               end
               twsl_pkg::ST_TX: begin
                  // data changes on the clock fall, bit 8 is master ack
                  // a byte counted from zero reloads from the data register,
                  // so a write just before that fall still reaches the bus
                  if (scl_fall) begin
                     if (byte_full) begin
                        ack_drive_r <= 1'b0;
                        bit_cnt_r <= 4'h0;
                        byte_done_r <= 1'b1;
                        ret_r <= twsl_pkg::ST_TX;
                        state_r <= twsl_pkg::ST_ACK;
                        ack_phase_r <= 1'b0;
                     end else begin
                        if (bit_cnt_r == 4'h0) shift_r <= {tx_data_r[6:0], 1'b0};
                        else shift_r <= {shift_r[6:0], 1'b0};
                        sda_slave_r <= (bit_cnt_r == 4'h0) ? tx_data_r[7] : shift_r[7];
                        ack_drive_r <= 1'b1;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                     end
                  end
               end
               twsl_pkg::ST_ACK: begin
                  // in tx, the master's ack bit is sampled here; nack ends
                  if (scl_rise) begin
                     ack_phase_r <= 1'b1;
                     if (ret_r == twsl_pkg::ST_TX && direction_r && !ack_drive_r && sda_s2_r)
                        ret_r <= twsl_pkg::ST_IDLE;
                  end else if (scl_fall && ack_phase_r) begin
                     if (ret_r == twsl_pkg::ST_TX) begin
                        sda_slave_r <= tx_data_r[7];
                        shift_r <= {tx_data_r[6:0], 1'b0};
                        bit_cnt_r <= 4'h1;
                        ack_drive_r <= 1'b1;
                     end else begin
                        ack_drive_r <= 1'b0;
                        sda_slave_r <= 1'b0;
                     end
                     state_r <= ret_r;
                  end
               end
               default: state_r <= twsl_pkg::ST_IDLE;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // pin drive: open drain style, slave pulls low only; spi owns pins when on
   // the slave only ever pulls data low, so a one is sent by letting go;
   // master data out is not forced to open drain, which lets software use
   // the pins as plain outputs when neither serial mode is wanted;
   // the outside pull-ups must hold the wires high while nobody drives
   wire ms_drive_sda = master_mode & drive_en & ~spi_enable_bit;
   wire sl_drive_sda = ~slave_hold & ack_drive_r & ~sda_slave_r;
   assign serial_data_pin_o = master_mode ? ctrl_r[twsl_pkg::BIT_SW_MASTER_DATA_OUT] : 1'b0;
   assign serial_data_pin_oe = ms_drive_sda | sl_drive_sda;
   assign serial_clock_pin_o = ctrl_r[twsl_pkg::BIT_SW_MASTER_CLOCK_OUT];
   assign serial_clock_pin_oe = master_mode & ~spi_enable_bit;
   // the interrupt request is the flag itself, so it clears with the flag
   assign irq = byte_done_r;

endmodule : twsl_port

// *** bench/twsl_port_chk.sv ***
// assertions on the two-wire port, bound to its ports
// assumes one ref_clk domain and resetn async active low
`timescale 1ns/1ps
module twsl_port_chk (
   // clock, reset, enable
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic clk_en,
   // register port
   input wire twsl_pkg::twsl_sfr_req_t sfr_req,
   input wire logic [7:0] sfr_rdata,
   // pins
   input wire logic spi_enable_bit,
   input wire logic serial_clock_pin_i,
   input wire logic serial_clock_pin_o,
   input wire logic serial_clock_pin_oe,
   input wire logic serial_data_pin_i,
   input wire logic serial_data_pin_o,
   input wire logic serial_data_pin_oe,
   input wire logic irq
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   // control byte read back through the mux is the reference
   wire ctl_sel = sfr_req.addr == twsl_pkg::ADDR_TWO_WIRE_CONTROL;
   wire acc = clk_en && (sfr_req.rd || sfr_req.wr);
   wire dat_acc = acc && sfr_req.addr == twsl_pkg::ADDR_BUS_DATA;
   wire own_wr = clk_en && sfr_req.wr && sfr_req.addr == twsl_pkg::ADDR_OWN_SLAVE_ADDRESS;
   wire rst_wr = clk_en && sfr_req.wr && ctl_sel && sfr_req.wdata[2] && !sfr_req.wdata[3];
   ////////////////////////////////////////////////////////////////////////////
   AST_CLK_OUT: assert property (ctl_sel |-> serial_clock_pin_o == sfr_rdata[5])
      else $error("clock pin differs from control");
   AST_CLK_OE: assert property (ctl_sel && $stable(spi_enable_bit) |->
      serial_clock_pin_oe == (sfr_rdata[3] && !spi_enable_bit))
      else $error("clock enable wrong");
   AST_DAT_MST: assert property (ctl_sel && sfr_rdata[3] && $stable(spi_enable_bit) |->
      serial_data_pin_o == sfr_rdata[7] && serial_data_pin_oe == (sfr_rdata[6] && !spi_enable_bit))
      else $error("master data pin wrong");
   AST_SLV_PINS: assert property (ctl_sel && !sfr_rdata[3] |->
      !serial_data_pin_o && !serial_clock_pin_oe) else $error("slave drives clock");
   AST_IRQ: assert property (ctl_sel |-> irq == sfr_rdata[0]) else $error("irq flag");
   // clock high a while, so no byte can finish on this edge
   AST_CLR: assert property (dat_acc && serial_clock_pin_i && $past(serial_clock_pin_i, 4)
      |=> !irq) else $error("data access kept irq");
   AST_OWN: assert property (own_wr ##1 sfr_req.addr == twsl_pkg::ADDR_OWN_SLAVE_ADDRESS
      |-> sfr_rdata == $past(sfr_req.wdata)) else $error("own address");
   AST_SPI: assert property (spi_enable_bit [*4] |->
      !serial_clock_pin_oe && !serial_data_pin_oe) else $error("pins driven under spi");
   AST_HOLD: assert property (rst_wr |-> ##2 !serial_data_pin_oe)
      else $error("held slave drives data");
   cover property (dat_acc && irq);
   cover property (serial_data_pin_oe && !serial_data_pin_o && !serial_clock_pin_oe);
   cover property (spi_enable_bit && ctl_sel && sfr_rdata[3]);
endmodule : twsl_port_chk
bind twsl_port twsl_port_chk i_twsl_port_chk (.*);

// *** bench/twsl_bus_master.sv ***
// outside two-wire master model, 80 ns bit period
// assumes pull-ups resolved by the bench, 1 means released
`timescale 1ns/1ps
module twsl_bus_master (
   // released-or-low levels
   output logic scl,
   output logic sda,
   // resolved data wire
   input wire logic sda_in
);
   // idle: clock stands still high between frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   ////////////////////////////////////////////////////////////////////////////
   // start: data falls while clock high
   task automatic start_c();
      sda = 1'b0;
      #40 scl = 1'b0;
      #20;
   endtask : start_c
   // stop: data rises while clock high
   task automatic stop_c();
      sda = 1'b0;
      #20 scl = 1'b1;
      #40 sda = 1'b1;
      #40;
   endtask : stop_c
   // nine bits msb first, sampled late in the high phase
   task automatic xbyte(input logic [8:0] tx, output logic [8:0] rx);
      for (int i = 8; i >= 0; i--) begin
         sda = tx[i];
         #20 scl = 1'b1;
         #40 rx[i] = sda_in;
         scl = 1'b0;
         #20;
      end
   endtask : xbyte
   // hold a data level for software-master reception
   task automatic put(input logic b);
      sda = b;
   endtask : put
endmodule : twsl_bus_master

// *** bench/twsl_port_tb.sv ***
// self-checking bench for the two-wire port
// assumes the master model and checker are compiled before it
`timescale 1ns/1ps
module twsl_port_tb;
   logic ref_clk = 1'b0, resetn = 1'b0, spi_enable_bit = 1'b0;
   twsl_pkg::twsl_sfr_req_t sfr_req = '0;
   logic [7:0] sfr_rdata;
   logic scl_o, scl_oe, sda_o, sda_oe, irq, m_scl, m_sda;
   int n_errors = 0, tests_run = 0;
   logic [31:0] seed = 32'h0000_0035;
   // open-drain wires with pull-ups
   wire scl_w = m_scl & (scl_oe ? scl_o : 1'b1);
   wire sda_w = m_sda & (sda_oe ? sda_o : 1'b1);
   always #2.5 ref_clk = ~ref_clk;
   twsl_port i_twsl_port (.ref_clk(ref_clk), .resetn(resetn), .clk_en(1'b1),
      .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .spi_enable_bit(spi_enable_bit),
      .serial_clock_pin_i(scl_w), .serial_clock_pin_o(scl_o), .serial_clock_pin_oe(scl_oe),
      .serial_data_pin_i(sda_w), .serial_data_pin_o(sda_o), .serial_data_pin_oe(sda_oe),
      .irq(irq));
   twsl_bus_master i_twsl_bus_master (.scl(m_scl), .sda(m_sda), .sda_in(sda_w));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : xs
   // expected {clock o, clock oe, data o, data oe}
   function automatic logic [7:0] pins_exp(input logic [7:0] c, input logic spi);
      return {4'h0, c[5], c[3] & !spi, c[7] & c[3], c[6] & c[3] & !spi};
   endfunction : pins_exp
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      tests_run++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      sfr_req <= '{1'b1, 1'b0, a, d};
      @(posedge ref_clk);
      sfr_req.wr <= 1'b0;
   endtask : wr
   // read data settles after this edge's updates, taken 1 ns after this edge
   task automatic rc(input string n, input logic [7:0] a, input logic [7:0] e);
      @(posedge ref_clk);
      sfr_req <= '{1'b0, 1'b1, a, 8'h00};
      #1 chk(n, e, sfr_rdata);
      @(posedge ref_clk);
      sfr_req.rd <= 1'b0;
   endtask : rc
   task automatic close_out();
      $display("checks %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : close_out
   // hang guard
   initial begin
      #400_000;
      n_errors++;
      close_out();
   end
   initial begin
      logic [7:0] v, d;
      logic [6:0] a;
      logic [8:0] r;
      logic m_in;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      rc("data", 8'h9a, twsl_pkg::RST_BUS_DATA);
      rc("own", 8'h9b, twsl_pkg::RST_OWN_SLAVE_ADDRESS);
      rc("unmapped", 8'h9c, 8'h00);
      wr(8'he8, 8'h12);
      rc("ctrl", 8'he8, 8'h00);
      // every master pin combination, then the spi takes the pins
      for (int i = 0; i < 8; i++) begin
         v = {3'(i), 5'h08};
         wr(8'he8, v);
         #1 chk("pins", pins_exp(v, 1'b0), {4'h0, scl_o, scl_oe, sda_o, sda_oe});
      end
      @(posedge ref_clk);
      spi_enable_bit <= 1'b1;
      repeat (5) @(posedge ref_clk);
      #1 chk("spi pins", pins_exp(v, 1'b1), {4'h0, scl_o, scl_oe, sda_o, sda_oe});
      @(posedge ref_clk);
      spi_enable_bit <= 1'b0;
      // software master reception on the clock rise
      repeat (4) begin
         v = 8'(xs());
         wr(8'he8, 8'h08);
         i_twsl_bus_master.put(v[0]);
         m_in = v[0];
         wr(8'he8, 8'h28);
         repeat (4) @(posedge ref_clk);
         rc("data in", 8'he8, {3'h1, v[0], 4'h8});
      end
      i_twsl_bus_master.put(1'b1);
      wr(8'he8, 8'h00);
      $display("test master pins done");
      for (int k = 0; k < 3; k++) begin
         v = 8'(xs());
         a = v[6:0];
         d = 8'(xs());
         wr(8'h9b, {1'b0, a});
         i_twsl_bus_master.start_c();
         i_twsl_bus_master.xbyte({a, 2'b01}, r);
         chk("addr ack", 8'h00, {7'h0, r[0]});
         i_twsl_bus_master.xbyte({d, 1'b1}, r);
         chk("rx ack", 8'h00, {7'h0, r[0]});
         i_twsl_bus_master.stop_c();
         chk("rx irq", 8'h01, {7'h0, irq});
         rc("rx data", 8'h9a, d);
         #1 chk("irq clear", 8'h00, {7'h0, irq});
         wr(8'h9a, ~d);
         i_twsl_bus_master.start_c();
         i_twsl_bus_master.xbyte({a, 2'b11}, r);
         rc("direction", 8'he8, {3'h0, m_in, 4'h2});
         i_twsl_bus_master.xbyte(9'h1ff, r);
         i_twsl_bus_master.stop_c();
         chk("tx data", ~d, r[8:1]);
         chk("tx irq", 8'h01, {7'h0, irq});
         rc("tx clear", 8'h9a, d);
      end
      $display("test slave transfers done");
      // foreign address, then own address while held in reset
      for (int k = 0; k < 2; k++) begin
         wr(8'he8, k != 0 ? 8'h04 : 8'h00);
         i_twsl_bus_master.start_c();
         i_twsl_bus_master.xbyte({k != 0 ? a : ~a, 2'b01}, r);
         i_twsl_bus_master.stop_c();
         chk("no ack", 8'h01, {7'h0, r[0]});
      end
      $display("test silent slave done");
      close_out();
   end
endmodule : twsl_port_tb
